// *** dv/line_receiver.sv ***
// Remote serial receiver model that decodes each lane's differential pair.
module line_receiver (
    input wire logic [3:0] txp_i,
    input wire logic [3:0] txn_i,
    output logic [3:0] bit_o,
    output logic [3:0] bad_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A pair whose two legs agree carries no valid symbol.
    assign bad_o = ~(txp_i ^ txn_i);
    assign bit_o = txp_i;
endmodule : line_receiver

// *** dv/serdes_tx_fir_pll_config_tb.sv ***
// Self-checking bench for the transmit and PLL configuration block.
module serdes_tx_fir_pll_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import serdes_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    av_req_s av_i = '0;
    logic [31:0] av_readdata_o;
    logic av_waitrequest_o, pll_lock_i = 1'b0, pll_enable_bit_o;
    logic [4:0] pll_multiply_factor_o;
    logic vco_low_range_select_o;
    logic [1:0] tx_rate_o;
    logic [5:0] link_active_o, radio_link_sync_field_o;
    logic [3:0] tx_lane_en_o, txp_o, txn_o, rx_bit, rx_bad;
    logic [3:0] tx_bit_i = 4'h0;
    lane_cfg_s [3:0] tx_cfg_o;
    logic [3:0][5:0] main_cursor_o;
    lane_cfg_s act [4] = '{default: '0};
    lane_cfg_s stg [4] = '{default: '0};
    logic [4:0] mtab [6] = '{5'h00, 5'h03, 5'h04, 5'h19, 5'h1a, 5'h1f};
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;

    serdes_tx_fir_pll_config serdes_tx_fir_pll_config_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .av_i(av_i),
        .av_readdata_o(av_readdata_o), .av_waitrequest_o(av_waitrequest_o),
        .pll_lock_i(pll_lock_i), .pll_enable_bit_o(pll_enable_bit_o),
        .pll_multiply_factor_o(pll_multiply_factor_o),
        .vco_low_range_select_o(vco_low_range_select_o),
        .tx_rate_o(tx_rate_o), .link_active_o(link_active_o),
        .radio_link_sync_field_o(radio_link_sync_field_o),
        .tx_lane_en_o(tx_lane_en_o), .tx_bit_i(tx_bit_i),
        .tx_cfg_o(tx_cfg_o), .main_cursor_o(main_cursor_o),
        .txp_o(txp_o), .txn_o(txn_o));

    line_receiver line_receiver_inst (.txp_i(txp_o), .txn_i(txn_o),
        .bit_o(rx_bit), .bad_o(rx_bad));

    always #25 clk_i = ~clk_i;

    task automatic final_report();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            $display("[ERR] t=%0t timeout", $time);
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // One Avalon transfer, entered and left just after a rising edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        av_i <= '{read: !w, write: w, address: a, writedata: d};
        @(posedge clk_i);
        while (av_waitrequest_o !== 1'b0) @(posedge clk_i);
        q = av_readdata_o;
        av_i <= '0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, string m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, e, m);
    endtask : rd

    function automatic logic [4:0] clampm(input logic [4:0] v);
        return (v < MPY_MIN) ? MPY_MIN : ((v > MPY_MAX) ? MPY_MAX : v);
    endfunction : clampm

    function automatic logic [5:0] act6(input logic [11:0] r);
        logic [5:0] a;
        for (int k = 0; k < 6; k++)
            a[k] = (r[2*k+:2] != 2'h0);
        return a;
    endfunction : act6

    function automatic logic [31:0] stat(input logic h, input logic [3:0] e);
        return {8'h00, e, 3'h0, h, 3'h0, RX_WORD_W, 7'h00, pll_lock_i};
    endfunction : stat

    // Trims the postcursor so the main cursor stays at or above half.
    function automatic lane_cfg_s legal(input lane_cfg_s v);
        if (5'(v.pre) + 5'(v.post[3:0]) > 5'h14)
            v.post[3] = 1'b0;
        return v;
    endfunction : legal

    task automatic lanes(input string m);
        @(negedge clk_i);
        for (int n = 0; n < NUM_LANES; n++) begin
            chk(32'(tx_cfg_o[n]), 32'(act[n]), m);
            chk(32'(main_cursor_o[n]), 32'(FULL_STEPS - 6'(act[n].pre)
                - 6'(act[n].post[3:0])), m);
        end
        @(posedge clk_i);
        for (int n = 0; n < NUM_LANES; n++)
            rd(OFS_ACT_BASE + 8'(4 * n), 32'(act[n]), m);
    endtask : lanes

    initial begin
        lane_cfg_s c;
        logic [31:0] q;
        logic [3:0] b, p;
        logic [4:0] mv;
        logic h;
        void'($urandom(32'he776dd41));
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rd(OFS_PLL_CTRL, 32'h0000_0040, "pll ctrl reset");
        rd(OFS_FIR_CTRL, 32'h0000_0001, "fir ctrl reset");
        rd(OFS_PLL_STAT, stat(1'b0, 4'h0), "status reset");
        chk(32'(tx_rate_o), 32'(RATE_HALF), "tx rate");
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            mv = (i < 6) ? mtab[i] : 5'($urandom);
            q = 32'({mv, 2'b00, 2'(i)});
            wr(OFS_PLL_CTRL, q);
            rd(OFS_PLL_CTRL, 32'({clampm(mv), 2'b00, 2'(i)}), "mpy");
            chk(32'({pll_multiply_factor_o, vco_low_range_select_o,
                pll_enable_bit_o}), 32'({clampm(mv), 2'(i)}), "pll");
        end
        $display("test pll done");
        for (int i = 0; i < 5; i++) begin
            q = (i == 0) ? 32'h0000_0555 : (i == 1) ? 32'h0002_a554
                : (32'($urandom) & 32'h0003_ffff);
            h = (q[11:0] == 12'h555);
            wr(OFS_LINK_RATE, q);
            rd(OFS_LINK_RATE, q, "link rate");
            chk(32'(link_active_o), 32'(act6(q[11:0])), "active");
            chk(32'(radio_link_sync_field_o), 32'(q[17:12]), "sync");
            rd(OFS_PLL_STAT, stat(h, 4'h0), "all half");
        end
        wr(OFS_LINK_RATE, 32'h0000_0555);
        h = 1'b1;
        $display("test rates done");
        wr(OFS_FIR_CTRL, 32'h0000_0000);
        for (int n = 0; n < NUM_LANES; n++) begin
            c = legal(13'($urandom));
            wr(OFS_LANE_BASE + 8'(4 * n), 32'(c));
            stg[n] = c;
            act[n] = c;
        end
        lanes("unlocked follow");
        pll_lock_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (int n = 0; n < NUM_LANES; n++) begin
                c = (i == 0 && n == 1) ? lane_cfg_s'(13'h1ffd)
                    : legal(13'($urandom));
                wr(OFS_LANE_BASE + 8'(4 * n), 32'(c));
                stg[n] = c;
                if (i == 3)
                    act[n] = c;
            end
            lanes((i == 3) ? "tied high follow" : "strobe low hold");
            if (i == 2) begin
                wr(OFS_FIR_CTRL, 32'h0000_0001);
                act = stg;
                lanes("strobe high load");
            end
        end
        $display("test latch done");
        for (int i = 0; i < 16; i++) begin
            b = 4'($urandom);
            for (int n = 0; n < NUM_LANES; n++)
                p[n] = act[n].pol;
            tx_bit_i <= b;
            @(posedge clk_i);
            @(negedge clk_i);
            chk(32'({txp_o, txn_o}), 32'({b ^ p, ~(b ^ p)}), "pair");
            chk(32'({rx_bit, rx_bad}), 32'({b ^ p, 4'h0}), "rx");
            @(posedge clk_i);
        end
        $display("test polarity done");
        wr(OFS_FIR_CTRL, 32'h0000_00f1);
        rd(OFS_PLL_STAT, stat(h, 4'hf), "lanes locked");
        pll_lock_i <= 1'b0;
        @(negedge clk_i);
        chk(32'(tx_lane_en_o), 32'h0000_0000, "lanes unlocked");
        @(posedge clk_i);
        for (int n = 0; n < NUM_LANES; n++) begin
            wr(OFS_LANE_BASE + 8'(4 * n), 32'h0000_0000);
            stg[n] = '0;
            act[n] = '0;
        end
        lanes("zero settings");
        wr(8'h40, $urandom);
        rd(8'h40, 32'h0000_0000, "unmapped");
        wr(OFS_PLL_STAT, 32'hffff_ffff);
        rd(OFS_PLL_STAT, stat(h, 4'h0), "status ro");
        $display("test misc done");
        final_report();
    end
endmodule : serdes_tx_fir_pll_config_tb

// *** rtl/serdes_cfg_pkg.sv ***
// Shared constants and types of the serializer transmit and PLL configuration.
package serdes_cfg_pkg;

    localparam int NUM_LANES = 4;
    localparam int NUM_LINKS = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_PLL_CTRL = 8'h00;
    localparam logic [7:0] OFS_PLL_STAT = 8'h04;
    localparam logic [7:0] OFS_LINK_RATE = 8'h08;
    localparam logic [7:0] OFS_FIR_CTRL = 8'h0C;
    localparam logic [7:0] OFS_LANE_BASE = 8'h10;
    localparam logic [7:0] OFS_ACT_BASE = 8'h20;

    // Field positions.
    localparam int PLL_EN_BIT = 0;
    localparam int VCO_LOW_BIT = 1;
    localparam int MPY_LSB = 4;
    localparam int MPY_W = 5;
    localparam int LOCK_BIT = 0;
    localparam int RXW_LSB = 8;
    localparam int RXW_W = 5;
    localparam int ALL_HALF_BIT = 16;
    localparam int LANE_ACT_LSB = 20;
    localparam int RATE_W = 2;
    localparam int SYNC_LSB = 12;
    localparam int STROBE_BIT = 0;
    localparam int LANE_EN_LSB = 4;
    localparam int LANE_CFG_W = 13;

    // Reset values and fixed figures.
    localparam logic [4:0] MPY_MIN = 5'h04;
    localparam logic [4:0] MPY_MAX = 5'h19;
    localparam logic [4:0] MPY_RST = 5'h04;
    localparam logic [1:0] RATE_HALF = 2'h1;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic STROBE_RST = 1'b1;
    localparam logic [4:0] RX_WORD_W = 5'h14;
    // Main cursor in 2.5 percent steps; 40 steps make 100 percent.
    localparam logic [5:0] FULL_STEPS = 6'h28;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } av_req_s;

    typedef struct packed {
        logic pol;
        logic [3:0] swing;
        logic [2:0] pre;
        logic [4:0] post;
    } lane_cfg_s;

endpackage : serdes_cfg_pkg

// *** rtl/serdes_tx_fir_pll_config.sv ***
// Register block for transmit lanes, radio link rates and the shared PLL.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
module serdes_tx_fir_pll_config (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire serdes_cfg_pkg::av_req_s av_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o,
    input wire logic pll_lock_i,
    output logic pll_enable_bit_o,
    output logic [4:0] pll_multiply_factor_o,
    output logic vco_low_range_select_o,
    output logic [1:0] tx_rate_o,
    output logic [5:0] link_active_o,
    output logic [5:0] radio_link_sync_field_o,
    output logic [3:0] tx_lane_en_o,
    input wire logic [3:0] tx_bit_i,
    output serdes_cfg_pkg::lane_cfg_s [3:0] tx_cfg_o,
    output logic [3:0][5:0] main_cursor_o,
    output logic [3:0] txp_o,
    output logic [3:0] txn_o
);
    import serdes_cfg_pkg::*;

    typedef struct packed {
        bus_e bus;
        logic [DATA_W-1:0] rdata;
        logic pll_en;
        logic vco_low;
        logic [MPY_W-1:0] pll_multiply_factor;
        logic [NUM_LINKS*RATE_W-1:0] rate;
        logic [NUM_LINKS-1:0] sync;
        logic strobe;
        logic [NUM_LANES-1:0] lane_en;
        lane_cfg_s [NUM_LANES-1:0] lane;
    } top_s;

    top_s s_r;
    top_s s_nxt;

    logic req;
    logic accept;
    logic lane_open;
    logic all_half;
    logic [1:0] lane_idx;
    logic lane_hit;
    logic act_hit;
    logic [DATA_W-1:0] rd;
    logic [MPY_W-1:0] mpy_wr;
    lane_cfg_s [NUM_LANES-1:0] act_cfg;

    assign req = av_i.read | av_i.write;
    assign accept = req && (s_r.bus == BUS_ACK);
    assign lane_idx = av_i.address[3:2];
    assign lane_hit = av_i.address[7:4] == OFS_LANE_BASE[7:4];
    assign act_hit = av_i.address[7:4] == OFS_ACT_BASE[7:4];
    assign mpy_wr = av_i.writedata[MPY_LSB +: MPY_W];
    // Latch stays transparent while the strobe is high or lock is absent.
    assign lane_open = s_r.strobe | ~pll_lock_i;

    always_comb begin
        all_half = 1'b1;
        for (int k = 0; k < NUM_LINKS; k++) begin
            if (s_r.rate[k*RATE_W +: RATE_W] != RATE_HALF) begin
                all_half = 1'b0;
            end
        end
    end

    always_comb begin
        rd = '0;
        if (lane_hit) begin
            rd[LANE_CFG_W-1:0] = s_r.lane[lane_idx];
        end else if (act_hit) begin
            rd[LANE_CFG_W-1:0] = act_cfg[lane_idx];
        end else begin
            case (av_i.address)
                OFS_PLL_CTRL: begin
                    rd[PLL_EN_BIT] = s_r.pll_en;
                    rd[VCO_LOW_BIT] = s_r.vco_low;
                    rd[MPY_LSB +: MPY_W] = s_r.pll_multiply_factor;
                end
                OFS_PLL_STAT: begin
                    rd[LOCK_BIT] = pll_lock_i;
                    rd[RXW_LSB +: RXW_W] = RX_WORD_W;
                    rd[ALL_HALF_BIT] = all_half;
                    rd[LANE_ACT_LSB +: NUM_LANES] = tx_lane_en_o;
                end
                OFS_LINK_RATE: begin
                    rd[NUM_LINKS*RATE_W-1:0] = s_r.rate;
                    rd[SYNC_LSB +: NUM_LINKS] = s_r.sync;
                end
                OFS_FIR_CTRL: begin
                    rd[STROBE_BIT] = s_r.strobe;
                    rd[LANE_EN_LSB +: NUM_LANES] = s_r.lane_en;
                end
                default: begin
                    rd = '0;
                end
            endcase
        end
    end

    always_comb begin
        s_nxt = s_r;
        case (s_r.bus)
            BUS_IDLE: begin
                if (req) begin
                    s_nxt.bus = BUS_ACK;
                    s_nxt.rdata = av_i.read ? rd : '0;
                end
            end
            BUS_ACK: begin
                s_nxt.bus = BUS_IDLE;
            end
            default: begin
                s_nxt.bus = BUS_IDLE;
            end
        endcase
        if (accept && av_i.write) begin
            if (lane_hit) begin
                // Only the addressed lane takes the write.
                s_nxt.lane[lane_idx] =
                    lane_cfg_s'(av_i.writedata[LANE_CFG_W-1:0]);
            end else begin
                case (av_i.address)
                    OFS_PLL_CTRL: begin
                        s_nxt.pll_en = av_i.writedata[PLL_EN_BIT];
                        s_nxt.vco_low = av_i.writedata[VCO_LOW_BIT];
                        // Out-of-range factors are pulled to the nearest end.
                        if (mpy_wr < MPY_MIN) begin
                            s_nxt.pll_multiply_factor = MPY_MIN;
                        end else if (mpy_wr > MPY_MAX) begin
                            s_nxt.pll_multiply_factor = MPY_MAX;
                        end else begin
                            s_nxt.pll_multiply_factor = mpy_wr;
                        end
                    end
                    OFS_LINK_RATE: begin
                        s_nxt.rate = av_i.writedata[NUM_LINKS*RATE_W-1:0];
                        s_nxt.sync = av_i.writedata[SYNC_LSB +: NUM_LINKS];
                    end
                    OFS_FIR_CTRL: begin
                        s_nxt.strobe = av_i.writedata[STROBE_BIT];
                        s_nxt.lane_en =
                            av_i.writedata[LANE_EN_LSB +: NUM_LANES];
                    end
                    default: begin
                        s_nxt.strobe = s_r.strobe;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r.bus <= BUS_IDLE;
            s_r.rdata <= '0;
            s_r.pll_en <= 1'b0;
            s_r.vco_low <= 1'b0;
            s_r.pll_multiply_factor <= MPY_RST;
            s_r.rate <= {NUM_LINKS{RATE_RST}};
            s_r.sync <= '0;
            s_r.strobe <= STROBE_RST;
            s_r.lane_en <= '0;
            s_r.lane <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : g_lane
            tx_lane_latch u_lane (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .cfg_i(s_r.lane[g]),
                .open_i(lane_open),
                .tx_bit_i(tx_bit_i[g]),
                .act_o(act_cfg[g]),
                .main_o(main_cursor_o[g]),
                .txp_o(txp_o[g]),
                .txn_o(txn_o[g])
            );
        end
    endgenerate

    always_comb begin
        for (int k = 0; k < NUM_LINKS; k++) begin
            link_active_o[k] = s_r.rate[k*RATE_W +: RATE_W] != RATE_RST;
        end
    end

    assign av_readdata_o = s_r.rdata;
    assign av_waitrequest_o = req && (s_r.bus != BUS_ACK);
    assign pll_enable_bit_o = s_r.pll_en;
    assign pll_multiply_factor_o = s_r.pll_multiply_factor;
    assign vco_low_range_select_o = s_r.vco_low;
    // The radio transmit path has no rate choice of its own.
    assign tx_rate_o = RATE_HALF;
    assign radio_link_sync_field_o = s_r.sync;
    // Lanes are held off until lock, whatever software asks for.
    assign tx_lane_en_o = s_r.lane_en & {NUM_LANES{pll_lock_i}};
    assign tx_cfg_o = act_cfg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_tx_half_rate: assert property (##1 tx_rate_o == RATE_HALF)
        else $error("transmit rate not half");
    a_rx_width_fixed: assert property (
        accept && av_i.read && av_i.address == OFS_PLL_STAT
        |-> av_readdata_o[RXW_LSB +: RXW_W] == 5'h14)
        else $error("receive width field not twenty");
    a_mpy_in_range: assert property (
        pll_multiply_factor_o >= 5'h04 && pll_multiply_factor_o <= 5'h19)
        else $error("multiply factor out of range");
    a_mpy_clamp_high: assert property (
        accept && av_i.write && av_i.address == OFS_PLL_CTRL
        && mpy_wr > 5'h19 |=> pll_multiply_factor_o == 5'h19)
        else $error("high multiply factor not clamped");
    a_lane_isolated: assert property (
        accept && av_i.write && lane_hit && lane_idx != 2'h0
        |=> $stable(s_r.lane[0]))
        else $error("lane zero disturbed by other lane write");
    a_swing_own: assert property (
        accept && av_i.write && lane_hit && lane_idx == 2'h1
        |=> s_r.lane[1].swing == $past(av_i.writedata[11:8]))
        else $error("lane swing not stored");
    a_strobe_low_freeze: assert property (
        !s_r.strobe && pll_lock_i ##1 !s_r.strobe && pll_lock_i
        |-> $stable(tx_cfg_o))
        else $error("active codes moved with strobe low");
    a_unlock_follow: assert property (
        !pll_lock_i ##1 1'b1 |-> tx_cfg_o == $past(s_r.lane))
        else $error("codes not following while unlocked");
    a_bus_answer: assert property (
        req && av_waitrequest_o |=> !av_waitrequest_o || !req)
        else $error("bus answer later than one cycle");
    a_lanes_need_lock: assert property (
        !pll_lock_i |-> tx_lane_en_o == 4'h0)
        else $error("lane enabled without lock");

    c_write_taken: cover property (accept && av_i.write);
    c_strobe_rise: cover property ($rose(s_r.strobe) && pll_lock_i);
    c_lock_loss: cover property ($fell(pll_lock_i));
    c_mpy_clamp: cover property (
        accept && av_i.write && av_i.address == OFS_PLL_CTRL && mpy_wr > 5'h19);

endmodule : serdes_tx_fir_pll_config

// *** rtl/tx_lane_latch.sv ***
// One transmit lane: latched filter codes, polarity and main cursor weight.
module tx_lane_latch (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire serdes_cfg_pkg::lane_cfg_s cfg_i,
    input wire logic open_i,
    input wire logic tx_bit_i,
    output serdes_cfg_pkg::lane_cfg_s act_o,
    output logic [5:0] main_o,
    output logic txp_o,
    output logic txn_o
);
    import serdes_cfg_pkg::*;

    typedef struct packed {
        lane_cfg_s act;
        logic txp;
    } lane_s;

    lane_s s_r;
    lane_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        // The latch is transparent while open; codes freeze when it closes.
        if (open_i) begin
            s_nxt.act = cfg_i;
        end
        s_nxt.txp = tx_bit_i ^ s_r.act.pol;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign act_o = s_r.act;
    assign txp_o = s_r.txp;
    assign txn_o = ~s_r.txp;
    // Full steps less precursor steps and postcursor magnitude; the sign bit is dropped.
    assign main_o = FULL_STEPS - {3'h0, s_r.act.pre}
        - {2'h0, s_r.act.post[3:0]};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_latch_closed_hold: assert property (!open_i |=> $stable(s_r.act))
        else $error("lane codes moved while latch closed");
    a_latch_open_load: assert property (open_i |=> s_r.act == $past(cfg_i))
        else $error("lane codes not loaded while latch open");
    a_pair_invert: assert property (
        ##1 txp_o == ($past(tx_bit_i) ^ $past(s_r.act.pol)) && txn_o == !txp_o)
        else $error("serial pair polarity wrong");
    a_main_weight: assert property (
        {2'h0, main_o} + {5'h0, act_o.pre} + {4'h0, act_o.post[3:0]} == 8'h28)
        else $error("main cursor weight mismatch");
    c_invert_used: cover property (s_r.act.pol && $rose(tx_bit_i));

endmodule : tx_lane_latch
